// ---- include/pcc_div_if.sv ----
// Purpose: carrier between the register bank and a rate divider
// Assumes: ratio is held steady by the register bank between writes
// Notes: tick is a one-cycle enable at clock divided by ratio
`timescale 1ns/1ps
`default_nettype none
interface pcc_div_if #(
  parameter int unsigned RW = 5
);
  logic [RW-1:0] ratio;
  logic tick;
  modport ctrl (output ratio, input tick);
  modport div (input ratio, output tick);
endinterface : pcc_div_if
`default_nettype wire

// ---- include/pcc_pkg.sv ----
// Purpose: constants for the pll divider and calibration control registers
// Assumes: 15-bit serial-port addresses, 8-bit register data
// Notes: widths, offsets, field positions and reset values live here only
package pcc_pkg;

  // ==========================================================================
  // serial port framing
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned INSTR_BITS = 16;
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned RW_BIT = 15;

  // ==========================================================================
  // register offsets
  localparam logic [14:0] OFS_LOOP_FILTER_THIRD = 15'h0089;
  localparam logic [14:0] OFS_CHARGE_PUMP = 15'h008A;
  localparam logic [14:0] OFS_OUTPUT_DIVIDER = 15'h008B;
  localparam logic [14:0] OFS_REFERENCE_DIVIDER = 15'h008C;
  localparam logic [14:0] OFS_REGULATOR = 15'h008D;
  localparam logic [14:0] OFS_AVERAGED_CAL = 15'h00E2;

  // ==========================================================================
  // field positions and widths
  localparam int unsigned POS_THIRD_RES_SKIP = 7;
  localparam int unsigned POS_FIRST_RES_SKIP = 6;
  localparam int unsigned POS_SECOND_CAP_SKIP = 5;
  localparam int unsigned POS_FIRST_CAP_SKIP = 4;
  localparam int unsigned FILTER_WORD_W = 4;
  localparam int unsigned PUMP_W = 6;
  localparam int unsigned OSC_SEL_W = 2;
  localparam int unsigned REF_SEL_W = 3;
  localparam int unsigned POS_CAL_TRIGGER = 1;
  localparam int unsigned POS_CAL_ALLOW = 0;
  localparam int unsigned RATIO_W = 5;

  // ==========================================================================
  // reset values
  localparam logic [3:0] RST_THIRD_RES_VALUE = 4'h8;
  localparam logic [5:0] RST_PUMP_CURRENT = 6'h20;
  localparam logic [1:0] RST_OSC_SELECT = 2'h2;
  localparam logic [2:0] RST_REF_SELECT = 3'h1;
  localparam logic [7:0] RST_REGULATOR = 8'h2B;

  // ==========================================================================
  // divide ratio encodings
  localparam logic [1:0] OSC_SEL_DIV4 = 2'h1;
  localparam logic [1:0] OSC_SEL_DIV8 = 2'h2;
  localparam logic [1:0] OSC_SEL_DIV16 = 2'h3;
  localparam logic [2:0] REF_SEL_DIV1 = 3'h0;
  localparam logic [2:0] REF_SEL_DIV2 = 3'h1;
  localparam logic [2:0] REF_SEL_DIV4 = 3'h2;
  localparam logic [2:0] REF_SEL_DIV8 = 3'h3;
  localparam logic [4:0] RATIO_1 = 5'h01;
  localparam logic [4:0] RATIO_2 = 5'h02;
  localparam logic [4:0] RATIO_4 = 5'h04;
  localparam logic [4:0] RATIO_8 = 5'h08;
  localparam logic [4:0] RATIO_16 = 5'h10;

endpackage : pcc_pkg

// ---- logic/pcc_cal_trig.sv ----
// Purpose: averaged calibration start on a rising edge of the trigger bit
// Assumes: trigger and allow come straight from register flip-flops
// Notes: an edge seen while calibration is not allowed is dropped
`timescale 1ns/1ps
`default_nettype none
module pcc_cal_trig (
  input wire logic clock,
  input wire logic resetn,
  input wire logic trigger,
  input wire logic allow,
  output logic start,
  output logic apply
);
  logic trig_prev_q;
  logic start_q;
  logic apply_q;
  logic rise;

  // ==========================================================================
  // edge detect
  assign rise = trigger & ~trig_prev_q;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      trig_prev_q <= 1'b0;
      start_q <= 1'b0;
      apply_q <= 1'b0;
    end
    else
    begin
      trig_prev_q <= trigger;
      start_q <= rise & allow; // [R9] [R11]
      apply_q <= allow; // [R11]
    end
  end

  assign start = start_q;
  assign apply = apply_q;
endmodule // pcc_cal_trig
`default_nettype wire

// ---- logic/pcc_divider.sv ----
// Purpose: rate divider producing a one-cycle enable every ratio cycles
// Assumes: ratio of zero is treated as one
// Notes: a shrinking ratio wraps the count at once, no long stall
`timescale 1ns/1ps
`default_nettype none
module pcc_divider #(
  parameter int unsigned RW = 5
) (
  input wire logic clock,
  input wire logic resetn,
  pcc_div_if.div dv
);
  logic [RW-1:0] cnt_q;
  logic [RW-1:0] cnt_d;
  logic tick_q;
  logic wrap;
  logic [RW-1:0] last;

  // ==========================================================================
  // count and wrap
  assign last = (dv.ratio == '0) ? '0 : dv.ratio - RW'(1);
  assign wrap = (cnt_q >= last);
  assign cnt_d = wrap ? '0 : cnt_q + RW'(1);

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= wrap;
    end
  end

  assign dv.tick = tick_q;
endmodule // pcc_divider
`default_nettype wire

// ---- logic/pcc_regs.sv ----
// Purpose: pll divider, loop filter and averaged calibration registers
// Assumes: serial port pins are synchronous to clock, clock well above sclk
// Notes: one byte per frame, 16-bit instruction then 8 data bits, msb first
//
// Summary of operation
// R1: output select code divides oscillator by 4/8/16
// R2: reference select code divides input 1..16
// R3: software keeps pll reference 35 to 80 MHz
// R4: software keeps oscillator between 6 and 12 GHz
// R5: skip bit bypasses filter element when word zero
// R6: third resistor word resets to 8
// R7: pump current field resets to 0x20
// R8: software writes regulator value 0x7B
// R9: trigger rising edge starts averaged calibration
// R10: software sets allow before raising trigger
// R11: allow bit permits calibration and applies results
// R12: reserved bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
module pcc_regs (
  input wire logic clock,
  input wire logic resetn,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic [pcc_pkg::FILTER_WORD_W-1:0] filter_first_res_word,
  input wire logic [pcc_pkg::FILTER_WORD_W-1:0] filter_second_cap_word,
  input wire logic [pcc_pkg::FILTER_WORD_W-1:0] filter_first_cap_word,
  output logic [pcc_pkg::FILTER_WORD_W-1:0] filter_third_res_value,
  output logic filter_third_res_bypass,
  output logic filter_first_res_bypass,
  output logic filter_second_cap_bypass,
  output logic filter_first_cap_bypass,
  output logic [pcc_pkg::PUMP_W-1:0] pump_current_value,
  output logic [pcc_pkg::OSC_SEL_W-1:0] oscillator_divide_select,
  output logic [pcc_pkg::REF_SEL_W-1:0] reference_divide_select,
  output logic [pcc_pkg::DATA_W-1:0] regulator_value,
  output logic conv_clk_en,
  output logic ref_clk_en,
  output logic averaged_cal_start,
  output logic averaged_cal_apply
);
  import pcc_pkg::*;

  // ==========================================================================
  // serial port front end
  logic sclk_q;
  logic [CNT_W-1:0] cnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic rd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] rd_sh_q;
  logic sdo_q;
  logic sdo_oe_q;
  logic sclk_rise;
  logic sclk_fall;
  logic [FRAME_BITS-1:0] shift_d;
  logic instr_done;
  logic wr_fire;
  logic [DATA_W-1:0] wdata;
  logic rd_phase;
  logic first_out;

  assign sclk_rise = ~spi_cs_n & spi_clk & ~sclk_q;
  assign sclk_fall = ~spi_cs_n & ~spi_clk & sclk_q;
  assign shift_d = {shift_q[FRAME_BITS-2:0], spi_sdi};
  assign instr_done = sclk_rise & (cnt_q == CNT_W'(INSTR_BITS - 1));
  assign wr_fire = sclk_rise & ~rd_q & (cnt_q == CNT_W'(FRAME_BITS - 1));
  assign wdata = shift_d[DATA_W-1:0];
  assign rd_phase = rd_q & (cnt_q >= CNT_W'(INSTR_BITS));
  assign first_out = sclk_fall & rd_q & (cnt_q == CNT_W'(INSTR_BITS));

  // bits beyond one frame are ignored; the count saturates until cs rises
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_q <= 1'b0;
      cnt_q <= '0;
      shift_q <= '0;
    end
    else
    begin
      sclk_q <= spi_clk;
      if (spi_cs_n)
        cnt_q <= '0;
      else if (sclk_rise && cnt_q != CNT_W'(FRAME_BITS))
      begin
        cnt_q <= cnt_q + CNT_W'(1);
        shift_q <= shift_d;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_q <= 1'b0;
      addr_q <= '0;
    end
    else if (spi_cs_n)
      rd_q <= 1'b0;
    else if (instr_done)
    begin
      rd_q <= shift_d[RW_BIT];
      addr_q <= shift_d[ADDR_W-1:0];
    end
  end

  // ==========================================================================
  // register storage
  logic [3:0] skip_q;
  logic [FILTER_WORD_W-1:0] third_word_q;
  logic [PUMP_W-1:0] pump_q;
  logic [OSC_SEL_W-1:0] osc_sel_q;
  logic [REF_SEL_W-1:0] ref_sel_q;
  logic [DATA_W-1:0] reg_val_q;
  logic cal_trig_q;
  logic cal_allow_q;
  logic hit_lf;
  logic hit_cp;
  logic hit_od;
  logic hit_rd;
  logic hit_ldo;
  logic hit_cal;

  assign hit_lf = (addr_q == OFS_LOOP_FILTER_THIRD);
  assign hit_cp = (addr_q == OFS_CHARGE_PUMP);
  assign hit_od = (addr_q == OFS_OUTPUT_DIVIDER);
  assign hit_rd = (addr_q == OFS_REFERENCE_DIVIDER);
  assign hit_ldo = (addr_q == OFS_REGULATOR);
  assign hit_cal = (addr_q == OFS_AVERAGED_CAL);

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      skip_q <= 4'h0; // [R5]
      third_word_q <= RST_THIRD_RES_VALUE; // [R6]
    end
    else if (wr_fire && hit_lf)
    begin
      skip_q <= wdata[POS_THIRD_RES_SKIP:POS_FIRST_CAP_SKIP];
      third_word_q <= wdata[FILTER_WORD_W-1:0];
    end
  end

  // only field bits are stored, so reserved bits drop written values
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      pump_q <= RST_PUMP_CURRENT; // [R7]
    else if (wr_fire && hit_cp)
      pump_q <= wdata[PUMP_W-1:0]; // [R12]
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      osc_sel_q <= RST_OSC_SELECT;
    else if (wr_fire && hit_od)
      osc_sel_q <= wdata[OSC_SEL_W-1:0]; // [R12]
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ref_sel_q <= RST_REF_SELECT;
    else if (wr_fire && hit_rd)
      ref_sel_q <= wdata[REF_SEL_W-1:0]; // [R12]
  end

  // reset value is not the operating value; software must rewrite it
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      reg_val_q <= RST_REGULATOR; // [R8]
    else if (wr_fire && hit_ldo)
      reg_val_q <= wdata;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cal_trig_q <= 1'b0;
      cal_allow_q <= 1'b0; // [R11]
    end
    else if (wr_fire && hit_cal)
    begin
      cal_trig_q <= wdata[POS_CAL_TRIGGER];
      cal_allow_q <= wdata[POS_CAL_ALLOW];
    end
  end

  // ==========================================================================
  // read back
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rd_lf;
  logic [DATA_W-1:0] rd_cp;
  logic [DATA_W-1:0] rd_od;
  logic [DATA_W-1:0] rd_rd;
  logic [DATA_W-1:0] rd_cal;

  assign rd_lf = {skip_q, third_word_q};
  assign rd_cp = {2'h0, pump_q}; // [R12]
  assign rd_od = {6'h00, osc_sel_q}; // [R12]
  assign rd_rd = {5'h00, ref_sel_q}; // [R12]
  assign rd_cal = {6'h00, cal_trig_q, cal_allow_q}; // [R12]
  assign rdata = hit_lf ? rd_lf :
                 hit_cp ? rd_cp :
                 hit_od ? rd_od :
                 hit_rd ? rd_rd :
                 hit_ldo ? reg_val_q :
                 hit_cal ? rd_cal : 8'h00;

  // data is shifted out on falling sclk so the host samples on rising
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_sh_q <= '0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end
    else
    begin
      sdo_oe_q <= ~spi_cs_n & rd_phase;
      if (first_out)
      begin
        sdo_q <= rdata[DATA_W-1];
        rd_sh_q <= {rdata[DATA_W-2:0], 1'b0};
      end
      else if (sclk_fall && rd_phase)
      begin
        sdo_q <= rd_sh_q[DATA_W-1];
        rd_sh_q <= {rd_sh_q[DATA_W-2:0], 1'b0};
      end
    end
  end

  // ==========================================================================
  // loop filter bypass decode
  logic [3:0] byp_q;
  logic [3:0] byp_d;

  assign byp_d[3] = skip_q[3] & (third_word_q == 4'h0); // [R5]
  assign byp_d[2] = skip_q[2] & (filter_first_res_word == 4'h0); // [R5]
  assign byp_d[1] = skip_q[1] & (filter_second_cap_word == 4'h0); // [R5]
  assign byp_d[0] = skip_q[0] & (filter_first_cap_word == 4'h0); // [R5]

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      byp_q <= 4'h0;
    else
      byp_q <= byp_d;
  end

  // ==========================================================================
  // divide ratio decode and rate dividers
  logic [RATIO_W-1:0] osc_ratio;
  logic [RATIO_W-1:0] ref_ratio;

  // code 00 is undefined; it is held at the lowest ratio rather than stall
  assign osc_ratio = (osc_sel_q == OSC_SEL_DIV8) ? RATIO_8 :
                     (osc_sel_q == OSC_SEL_DIV16) ? RATIO_16 :
                     RATIO_4; // [R1]
  // codes above 100 are undefined and held at the largest ratio
  assign ref_ratio = (ref_sel_q == REF_SEL_DIV1) ? RATIO_1 :
                     (ref_sel_q == REF_SEL_DIV2) ? RATIO_2 :
                     (ref_sel_q == REF_SEL_DIV4) ? RATIO_4 :
                     (ref_sel_q == REF_SEL_DIV8) ? RATIO_8 :
                     RATIO_16; // [R2]

  pcc_div_if #(.RW(RATIO_W)) osc_if ();
  pcc_div_if #(.RW(RATIO_W)) ref_if ();

  assign osc_if.ratio = osc_ratio;
  assign ref_if.ratio = ref_ratio;

  pcc_divider #(.RW(RATIO_W)) u_osc_div (
    .clock(clock),
    .resetn(resetn),
    .dv(osc_if)
  );

  pcc_divider #(.RW(RATIO_W)) u_ref_div (
    .clock(clock),
    .resetn(resetn),
    .dv(ref_if)
  );

  // ==========================================================================
  // averaged calibration
  pcc_cal_trig u_cal (
    .clock(clock),
    .resetn(resetn),
    .trigger(cal_trig_q),
    .allow(cal_allow_q),
    .start(averaged_cal_start),
    .apply(averaged_cal_apply)
  );

  // ==========================================================================
  // outputs
  assign spi_sdo = sdo_q;
  assign spi_sdo_oe = sdo_oe_q;
  assign filter_third_res_value = third_word_q;
  assign filter_third_res_bypass = byp_q[3];
  assign filter_first_res_bypass = byp_q[2];
  assign filter_second_cap_bypass = byp_q[1];
  assign filter_first_cap_bypass = byp_q[0];
  assign pump_current_value = pump_q;
  assign oscillator_divide_select = osc_sel_q;
  assign reference_divide_select = ref_sel_q;
  assign regulator_value = reg_val_q;
  assign conv_clk_en = osc_if.tick;
  assign ref_clk_en = ref_if.tick;
endmodule // pcc_regs
`default_nettype wire

// ---- tb/pcc_regs_assertions.sv ----
// Purpose: port assertions for pcc_regs
// Assumes: one clock, resetn async active low
// Notes: divider spacing is judged only while its select holds
`timescale 1ns/1ps
`default_nettype none
module pcc_regs_assertions (
  input wire logic clock,
  input wire logic resetn,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  input wire logic [3:0] filter_first_res_word,
  input wire logic [3:0] filter_third_res_value,
  input wire logic filter_third_res_bypass,
  input wire logic filter_first_res_bypass,
  input wire logic [5:0] pump_current_value,
  input wire logic [1:0] oscillator_divide_select,
  input wire logic [2:0] reference_divide_select,
  input wire logic [7:0] regulator_value,
  input wire logic conv_clk_en,
  input wire logic ref_clk_en,
  input wire logic averaged_cal_start,
  input wire logic averaged_cal_apply
);
  default clocking dck @(posedge clock); endclocking
  default disable iff (!resetn);
  // ====================
  // gap counters, disarmed by a select change since the divider count runs on across it
  logic [4:0] cgap_q, rgap_q;
  logic [1:0] osel_q;
  logic [2:0] rsel_q;
  logic carm_q, rarm_q;
  wire cchg = oscillator_divide_select != osel_q;
  wire rchg = reference_divide_select != rsel_q;
  // shift amount widened to 3 bits so select 3 gives 16, not a wrap to 1
  wire [4:0] crat = (oscillator_divide_select < 2'h2) ? 5'h04 :
    5'h01 << (oscillator_divide_select + 3'h1);
  wire [4:0] rrat = (reference_divide_select > 3'h3) ? 5'h10 :
    5'h01 << reference_divide_select;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cgap_q <= 5'h00;
      rgap_q <= 5'h00;
      osel_q <= 2'h2;
      rsel_q <= 3'h1;
      carm_q <= 1'b0;
      rarm_q <= 1'b0;
    end
    else
    begin
      cgap_q <= conv_clk_en ? 5'h01 : cgap_q + 5'h01;
      rgap_q <= ref_clk_en ? 5'h01 : rgap_q + 5'h01;
      osel_q <= oscillator_divide_select;
      rsel_q <= reference_divide_select;
      carm_q <= !cchg && (conv_clk_en || carm_q);
      rarm_q <= !rchg && (ref_clk_en || rarm_q);
    end
  end
  // ====================
  // assertions
  AST_CONV_GAP: assert property (
    carm_q && !cchg |-> (conv_clk_en ? cgap_q == crat : cgap_q < crat))
    else $error("conv enable spacing wrong");
  AST_REF_GAP: assert property (
    rarm_q && !rchg |-> (ref_clk_en ? rgap_q == rrat : rgap_q < rrat))
    else $error("ref enable spacing wrong");
  AST_THIRD_BYP: assert property (
    filter_third_res_bypass |-> $past(filter_third_res_value) == 4'h0)
    else $error("third bypass with nonzero word");
  AST_FIRST_BYP: assert property (
    filter_first_res_bypass |-> $past(filter_first_res_word) == 4'h0)
    else $error("first bypass with nonzero word");
  AST_RESET_VALS: assert property (
    $rose(resetn) |-> filter_third_res_value == 4'h8 &&
    pump_current_value == 6'h20 && !averaged_cal_apply)
    else $error("reset value wrong");
  AST_START_APPLY: assert property (
    averaged_cal_start |-> averaged_cal_apply)
    else $error("start while not allowed");
  AST_START_PULSE: assert property (
    averaged_cal_start |=> !averaged_cal_start)
    else $error("start longer than one cycle");
  AST_OE_IDLE: assert property (
    spi_cs_n && $past(spi_cs_n) |-> !spi_sdo_oe)
    else $error("sdo enabled outside frame");
  AST_SDO_ON_FALL: assert property (
    spi_sdo_oe && $past(spi_sdo_oe) && $changed(spi_sdo) |-> !$past(spi_clk))
    else $error("sdo moved without serial clock fall");
endmodule // pcc_regs_assertions
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for pcc_regs
// Assumes: serial bit of 4 low and 3 high core clocks
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock, resetn, spi_clk, spi_cs_n, spi_sdi;
  logic [3:0] filter_first_res_word, filter_second_cap_word;
  logic [3:0] filter_first_cap_word;
  wire spi_sdo, spi_sdo_oe, conv_clk_en, ref_clk_en;
  wire averaged_cal_start, averaged_cal_apply;
  wire filter_third_res_bypass, filter_first_res_bypass;
  wire filter_second_cap_bypass, filter_first_cap_bypass;
  wire [3:0] filter_third_res_value;
  wire [5:0] pump_current_value;
  wire [1:0] oscillator_divide_select;
  wire [2:0] reference_divide_select;
  wire [7:0] regulator_value;
  int n_errors, compares, cyc, n_start;
  logic [14:0] ofs [6] = '{15'h0089, 15'h008A, 15'h008B, 15'h008C,
    15'h008D, 15'h00E2};
  logic [7:0] rst [6] = '{8'h08, 8'h20, 8'h02, 8'h01, 8'h2B, 8'h00};
  logic [7:0] msk [6] = '{8'hFF, 8'h3F, 8'h03, 8'h07, 8'hFF, 8'h03};
  pcc_regs pcc_regs_inst (.clock, .resetn, .spi_clk, .spi_cs_n, .spi_sdi,
    .spi_sdo, .spi_sdo_oe, .filter_first_res_word, .filter_second_cap_word,
    .filter_first_cap_word, .filter_third_res_value, .filter_third_res_bypass,
    .filter_first_res_bypass, .filter_second_cap_bypass,
    .filter_first_cap_bypass, .pump_current_value, .oscillator_divide_select,
    .reference_divide_select, .regulator_value, .conv_clk_en, .ref_clk_en,
    .averaged_cal_start, .averaged_cal_apply);
  // ====================
  // clock, hang guard, start counter
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (averaged_cal_start === 1'b1)
      n_start++;
    if (cyc == 20000)
    begin
      n_errors++;
      close_out();
    end
  end
  // ====================
  // shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // nb below 24 drops select mid-frame
  task automatic spi(input logic rd, input logic [14:0] a,
    input logic [7:0] d, input int nb, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 24 - nb; i--)
    begin
      spi_sdi = f[i];
      step(4);
      if (i < 8)
        q[i] = spi_sdo;
      spi_clk = 1'b1;
      step(3);
      spi_clk = 1'b0;
    end
    step(3);
    spi_cs_n = 1'b1;
    step(3);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi(1'b0, a, d, 24, q);
  endtask
  task automatic rdc(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] q;
    spi(1'b1, a, 8'h00, 24, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic gap(input logic w, output logic [7:0] n);
    n = 8'h00;
    while (n < 40 && (w ? ref_clk_en : conv_clk_en) !== 1'b1)
    begin
      step(1);
      n++;
    end
    n = 8'h00;
    do
    begin
      step(1);
      n++;
    end
    while (n < 40 && (w ? ref_clk_en : conv_clk_en) !== 1'b1);
  endtask
  // ====================
  // scenarios
  task automatic t_access();
    logic [7:0] q;
    for (int i = 0; i < 6; i++)
      rdc(ofs[i], rst[i]);
    for (int i = 0; i < 6; i++)
    begin
      wr(ofs[i], 8'hFF);
      rdc(ofs[i], msk[i]);
    end
    wr(15'h00E3, 8'h5A);
    rdc(15'h00E3, 8'h00);
    spi(1'b0, 15'h008D, 8'h7B, 20, q);
    rdc(15'h008D, 8'hFF);
    wr(15'h008D, 8'h7B);
    chk("regulator", 8'h7B, regulator_value);
    wr(15'h0089, 8'h0E);
    chk("third word", 8'h0E, 8'(filter_third_res_value));
    wr(15'h008A, 8'h12);
    chk("pump", 8'h12, 8'(pump_current_value));
  endtask
  task automatic t_div();
    logic [7:0] g;
    for (int s = 1; s < 4; s++)
    begin
      wr(15'h008B, 8'(s));
      gap(1'b0, g);
      chk("conv gap", 8'h01 << (s + 1), g);
    end
    for (int s = 0; s < 5; s++)
    begin
      wr(15'h008C, 8'(s));
      gap(1'b1, g);
      chk("ref gap", 8'h01 << s, g);
    end
    // leave a working setup: /2 reference and /8 oscillator
    wr(15'h008C, 8'h01);
    chk("ref select", 8'h01, 8'(reference_divide_select));
    wr(15'h008B, 8'h02);
    chk("osc select", 8'h02, 8'(oscillator_divide_select));
  endtask
  task automatic t_byp();
    filter_first_res_word = 4'h0;
    filter_second_cap_word = 4'h5;
    wr(15'h0089, 8'hF0);
    chk("bypass", 8'h0D, {4'h0, filter_third_res_bypass,
      filter_first_res_bypass, filter_second_cap_bypass,
      filter_first_cap_bypass});
    filter_first_res_word = 4'h3;
    filter_second_cap_word = 4'h0;
    wr(15'h0089, 8'hF1);
    chk("bypass", 8'h03, {4'h0, filter_third_res_bypass,
      filter_first_res_bypass, filter_second_cap_bypass,
      filter_first_cap_bypass});
    wr(15'h0089, 8'h00);
    chk("bypass", 8'h00, {4'h0, filter_third_res_bypass,
      filter_first_res_bypass, filter_second_cap_bypass,
      filter_first_cap_bypass});
  endtask
  task automatic t_cal();
    int n0;
    wr(15'h00E2, 8'h00);
    n0 = n_start;
    wr(15'h00E2, 8'h02);
    chk("starts", 8'h00, 8'(n_start - n0));
    wr(15'h00E2, 8'h00);
    wr(15'h00E2, 8'h01);
    chk("apply", 8'h01, 8'(averaged_cal_apply));
    wr(15'h00E2, 8'h03);
    chk("starts", 8'h01, 8'(n_start - n0));
    wr(15'h00E2, 8'h00);
    chk("apply", 8'h00, 8'(averaged_cal_apply));
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    resetn = 1'b0;
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
    filter_first_res_word = 4'h0;
    filter_second_cap_word = 4'h0;
    filter_first_cap_word = 4'h0;
    step(3);
    resetn = 1'b1;
    step(1);
    t_access();
    $display("test access done");
    t_div();
    $display("test dividers done");
    t_byp();
    $display("test bypass done");
    t_cal();
    $display("test calibration done");
    close_out();
  end
endmodule // tb_top
bind pcc_regs pcc_regs_assertions pcc_regs_assertions_inst (.clock, .resetn,
  .spi_clk, .spi_cs_n, .spi_sdo, .spi_sdo_oe, .filter_first_res_word,
  .filter_third_res_value, .filter_third_res_bypass, .filter_first_res_bypass,
  .pump_current_value, .oscillator_divide_select, .reference_divide_select,
  .regulator_value, .conv_clk_en, .ref_clk_en, .averaged_cal_start,
  .averaged_cal_apply);
`default_nettype wire
